// ==== logic/cdr_lock_pkg.sv ====
// Constants and types shared by the reclocker frequency-acquisition logic.
// Assumes the serial host register file lives outside and feeds the fields in.
package cdr_lock_pkg;

  localparam int CHANNELS = 4;

  // Reference-control register field holding the global reference divider
  localparam int RFD_LSB = 1;
  localparam int RFD_MSB = 3;

  // Lock-window control register layout and its power-up value
  localparam int ACQ_LSB = 5;
  localparam int NARROW_LSB = 1;
  localparam int WIDE_BIT = 0;
  localparam logic [7:0] WINDOW_CTRL_DEFAULT = 8'ha8;

  // Comparison frequency limits, kept by the host through divider choice
  localparam real CMP_FREQ_MIN_MHZ = 10.0;
  localparam real CMP_FREQ_MAX_MHZ = 25.0;

  // Averaging interval is 1 << (BASE + acquisition setting) scaled-reference periods
  localparam int INTERVAL_BASE_SHIFT = 4;
  localparam int WIN_CNT_W = 12;
  localparam int VCO_CNT_W = 13;

  typedef struct packed {
    logic [2:0] acq;
    logic [3:0] narrow;
    logic wide;
  } window_cfg_t;

  typedef enum logic {st_acquire, st_locked} lock_state_t;

  // Reference divider code to divide ratio; unused code falls back to 1
  function automatic logic [5:0] rfd_ratio(input logic [2:0] code);
    case (code)
      3'h0: rfd_ratio = 6'h01;
      3'h1: rfd_ratio = 6'h02;
      3'h2: rfd_ratio = 6'h04;
      3'h3: rfd_ratio = 6'h08;
      3'h4: rfd_ratio = 6'h0c;
      3'h5: rfd_ratio = 6'h10;
      3'h6: rfd_ratio = 6'h20;
      default: rfd_ratio = 6'h01;
    endcase
  endfunction

endpackage

// ==== logic/cdr_lock_detector.sv ====
// Per-channel frequency window detector and secondary loop control, four channels.
// Assumes slowed reference and VCO tick levels arriving asynchronously on pins,
// and divider/window settings driven from the host register file.
`timescale 1ns/100ps
`default_nettype none

module cdr_lock_detector import cdr_lock_pkg::*; (
  input wire logic clk_in, // 40 MHz system clock
  input wire logic rst_n_in, // Synchronous reset, active low
  input wire logic ref_tick_in, // Reference tick level from pin
  input wire logic [CHANNELS-1:0] vco_tick_in, // Prescaled VCO tick levels
  input wire logic [7:0] reference_clock_control_in, // Global reference control register
  input wire logic [CHANNELS-1:0][7:0] channel_vco_compare_divider_in, // Per-channel VCO divider
  input wire logic [CHANNELS-1:0][7:0] lock_window_control_in, // Per-channel window control
  input wire logic [CHANNELS-1:0] activity_loss_flag_in, // Loss of activity, same clock
  input wire logic [CHANNELS-1:0] soft_reset_in, // Per-channel soft reset, level
  output logic [CHANNELS-1:0] lock_alarm_bit_out, // Lock loss alarm, active high
  output logic [CHANNELS-1:0] lock_loss_pin_n_out, // Open-drain lock loss pin data
  output logic [CHANNELS-1:0] lock_loss_pin_n_oe_out, // Pin drive enable, high pulls low
  output logic [CHANNELS-1:0] fll_enable_out // Secondary frequency loop enable
);

  function automatic logic [VCO_CNT_W-1:0] abs_diff(input logic [VCO_CNT_W-1:0] a,
                                                   input logic [VCO_CNT_W-1:0] b);
    abs_diff = (a > b) ? a - b : b - a;
  endfunction

  // Synchronisers; only the second stage and beyond are looked at
  logic ref_meta_q, ref_sync_q, ref_last_q;
  logic [CHANNELS-1:0] vco_meta_q, vco_sync_q, vco_last_q;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ref_meta_q <= 1'b0;
      ref_sync_q <= 1'b0;
      ref_last_q <= 1'b0;
      vco_meta_q <= '0;
      vco_sync_q <= '0;
      vco_last_q <= '0;
    end else begin
      ref_meta_q <= ref_tick_in;
      ref_sync_q <= ref_meta_q;
      ref_last_q <= ref_sync_q;
      vco_meta_q <= vco_tick_in;
      vco_sync_q <= vco_meta_q;
      vco_last_q <= vco_sync_q;
    end
  end

  logic ref_rise;
  logic [CHANNELS-1:0] vco_rise;
  assign ref_rise = ref_sync_q & ~ref_last_q;
  assign vco_rise = vco_sync_q & ~vco_last_q;

  // Global reference divider feeding every channel
  logic [5:0] ref_div_q;
  logic [5:0] ref_ratio;
  logic scaled_ref_freq;
  assign ref_ratio = rfd_ratio(reference_clock_control_in[RFD_MSB:RFD_LSB]);
  assign scaled_ref_freq = ref_rise && (ref_div_q >= ref_ratio - 6'h01);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ref_div_q <= '0;
    end else if (scaled_ref_freq) begin
      ref_div_q <= '0;
    end else if (ref_rise) begin
      ref_div_q <= ref_div_q + 6'h01;
    end
  end

  window_cfg_t [CHANNELS-1:0] cfg;
  logic [CHANNELS-1:0][7:0] vco_div_q;
  logic [CHANNELS-1:0] scaled_vco_freq;
  logic [CHANNELS-1:0][WIN_CNT_W-1:0] win_cnt_q;
  logic [CHANNELS-1:0][WIN_CNT_W-1:0] interval_len;
  logic [CHANNELS-1:0][VCO_CNT_W-1:0] vco_cnt_q;
  logic [CHANNELS-1:0][VCO_CNT_W-1:0] vco_total;
  logic [CHANNELS-1:0][VCO_CNT_W-1:0] freq_diff;
  logic [CHANNELS-1:0][VCO_CNT_W-1:0] narrow_cnt;
  logic [CHANNELS-1:0][VCO_CNT_W-1:0] wide_cnt;
  logic [CHANNELS-1:0] interval_end;
  lock_state_t [CHANNELS-1:0] state_q;

  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      cfg[c] = window_cfg_t'(lock_window_control_in[c]);
      // A divider value of zero wraps through all 256 counts
      scaled_vco_freq[c] = vco_rise[c] && (vco_div_q[c] == channel_vco_compare_divider_in[c] - 8'h01);
      interval_len[c] = WIN_CNT_W'(1) << (INTERVAL_BASE_SHIFT + int'(cfg[c].acq));
      interval_end[c] = scaled_ref_freq && (win_cnt_q[c] == interval_len[c] - WIN_CNT_W'(1));
      vco_total[c] = (scaled_vco_freq[c] && !(&vco_cnt_q[c])) ? vco_cnt_q[c] + VCO_CNT_W'(1) : vco_cnt_q[c];
      freq_diff[c] = abs_diff(vco_total[c], VCO_CNT_W'(interval_len[c]));
      narrow_cnt[c] = VCO_CNT_W'(cfg[c].narrow);
      // Wide select trades a tight 1.5x margin against a 4x one
      wide_cnt[c] = cfg[c].wide ? narrow_cnt[c] << 2 : narrow_cnt[c] + (narrow_cnt[c] >> 1);
    end
  end

  always_ff @(posedge clk_in) begin
    for (int c = 0; c < CHANNELS; c++) begin
      if (!rst_n_in || soft_reset_in[c]) begin
        vco_div_q[c] <= '0;
      end else if (scaled_vco_freq[c]) begin
        vco_div_q[c] <= '0;
      end else if (vco_rise[c]) begin
        vco_div_q[c] <= vco_div_q[c] + 8'h01;
      end
    end
  end

  // Averaging counters restart every interval
  always_ff @(posedge clk_in) begin
    for (int c = 0; c < CHANNELS; c++) begin
      if (!rst_n_in || soft_reset_in[c] || interval_end[c]) begin
        win_cnt_q[c] <= '0;
        vco_cnt_q[c] <= '0;
      end else begin
        vco_cnt_q[c] <= vco_total[c];
        if (scaled_ref_freq) begin
          win_cnt_q[c] <= win_cnt_q[c] + WIN_CNT_W'(1);
        end
      end
    end
  end

  // Hysteresis between the narrow and wide windows
  always_ff @(posedge clk_in) begin
    for (int c = 0; c < CHANNELS; c++) begin
      if (!rst_n_in || soft_reset_in[c]) begin
        state_q[c] <= st_acquire;
      end else if (interval_end[c]) begin
        case (state_q[c])
          st_acquire: begin
            // Without activity the loop stays on so the VCO holds the reference
            if (freq_diff[c] <= narrow_cnt[c] && !activity_loss_flag_in[c]) begin
              state_q[c] <= st_locked;
            end
          end
          st_locked: begin
            if (freq_diff[c] > wide_cnt[c]) begin
              state_q[c] <= st_acquire;
            end
          end
          default: state_q[c] <= st_acquire;
        endcase
      end
    end
  end

  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      lock_alarm_bit_out[c] = (state_q[c] == st_acquire);
      fll_enable_out[c] = (state_q[c] == st_acquire);
      lock_loss_pin_n_oe_out[c] = (state_q[c] == st_acquire);
    end
  end
  assign lock_loss_pin_n_out = '0;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_ref_div_wrap: assert property (scaled_ref_freq |=> ref_div_q == 6'h00)
    else $error("reference divider did not restart after output pulse");

  for (genvar g = 0; g < CHANNELS; g++) begin : g_chk
    sequence s_narrow_hit;
      interval_end[g] && state_q[g] == st_acquire && freq_diff[g] <= narrow_cnt[g] && !activity_loss_flag_in[g];
    endsequence
    sequence s_wide_miss;
      interval_end[g] && state_q[g] == st_locked && freq_diff[g] > wide_cnt[g];
    endsequence

    a_loop_follows_loss: assert property (fll_enable_out[g] == lock_alarm_bit_out[g])
      else $error("frequency loop enable differs from lock loss");
    a_clear_in_narrow: assert property ($fell(lock_alarm_bit_out[g]) |-> $past(interval_end[g])
      && $past(freq_diff[g]) <= $past(narrow_cnt[g]))
      else $error("lock loss cleared outside narrow window");
    a_narrow_clears: assert property ((s_narrow_hit and !soft_reset_in[g]) |=> !lock_alarm_bit_out[g])
      else $error("lock loss not cleared inside narrow window");
    a_wide_sets: assert property (s_wide_miss |=> lock_alarm_bit_out[g])
      else $error("lock loss not set beyond wide window");
    a_set_only_wide: assert property ($rose(lock_alarm_bit_out[g]) && !$past(soft_reset_in[g])
      |-> $past(interval_end[g]) && $past(freq_diff[g]) > $past(wide_cnt[g]))
      else $error("lock loss set inside wide window");
    a_activity_holds: assert property (lock_alarm_bit_out[g] && activity_loss_flag_in[g]
      |=> lock_alarm_bit_out[g])
      else $error("frequency loop dropped during activity loss");
    a_hold_between: assert property (!interval_end[g] && !soft_reset_in[g]
      |=> $stable(lock_alarm_bit_out[g]))
      else $error("lock decision changed inside averaging interval");
    a_pin_on_loss: assert property (lock_alarm_bit_out[g] |-> lock_loss_pin_n_oe_out[g]
      && !lock_loss_pin_n_out[g])
      else $error("lock loss pin not pulled low");
    a_interval_restart: assert property (interval_end[g] |=> win_cnt_q[g] == '0 && vco_cnt_q[g] == '0)
      else $error("averaging counters not restarted");
    a_vcd_wrap: assert property (scaled_vco_freq[g] |=> vco_div_q[g] == 8'h00)
      else $error("VCO comparison divider did not restart");
  end

endmodule

`default_nettype wire

// ==== test/tick_source.sv ====
// Far-side model: reference and per-channel VCO tick levels.
// Assumes the bench sets the tick periods, each at least four clocks.
`timescale 1ns/100ps
`default_nettype none

module tick_source (
  input wire logic clk_in, // System clock
  input wire logic [7:0] ref_period_in, // Reference period in clocks
  input wire logic [3:0][7:0] vco_period_in, // VCO periods in clocks
  output logic ref_tick_out, // Reference tick level
  output logic [3:0] vco_tick_out // VCO tick levels
);
  logic [7:0] ref_cnt_q = 8'h00;
  logic [3:0][7:0] vco_cnt_q = '0;

  // High two clocks per period so the synchroniser never misses an edge
  always_ff @(posedge clk_in) begin
    ref_cnt_q <= (ref_cnt_q + 8'h01 >= ref_period_in) ? 8'h00 : ref_cnt_q + 8'h01;
    ref_tick_out <= ref_cnt_q < 8'h02;
    for (int c = 0; c < 4; c++) begin
      vco_cnt_q[c] <= (vco_cnt_q[c] + 8'h01 >= vco_period_in[c]) ? 8'h00 : vco_cnt_q[c] + 8'h01;
      vco_tick_out[c] <= vco_cnt_q[c] < 8'h02;
    end
  end
endmodule

`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the four-channel lock detector.
// Assumes tick_source drives the tick pins; registers are driven as levels.
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end

module tb import cdr_lock_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ref_tick;
  logic [3:0] vco_tick;
  logic [7:0] refctl = 8'h00;
  logic [3:0][7:0] vdiv = {4{8'h01}};
  logic [3:0][7:0] win = {4{8'h25}};
  logic [3:0] act = 4'h0;
  logic [3:0] srst = 4'h0;
  logic [7:0] ref_per = 8'h04;
  logic [3:0][7:0] vco_per = {4{8'h04}};
  logic [3:0] alarm, pin_n, pin_oe, fll;
  int error_cnt = 0;
  int checked = 0;
  int ratios [7] = '{1, 2, 4, 8, 12, 16, 32};

  initial begin
    forever #12.5 clk = ~clk;
  end

  tick_source u_tick_source (.clk_in(clk), .ref_period_in(ref_per), .vco_period_in(vco_per),
    .ref_tick_out(ref_tick), .vco_tick_out(vco_tick));

  cdr_lock_detector u_cdr_lock_detector (.clk_in(clk), .rst_n_in(rst_n), .ref_tick_in(ref_tick),
    .vco_tick_in(vco_tick), .reference_clock_control_in(refctl), .channel_vco_compare_divider_in(vdiv),
    .lock_window_control_in(win), .activity_loss_flag_in(act), .soft_reset_in(srst),
    .lock_alarm_bit_out(alarm), .lock_loss_pin_n_out(pin_n), .lock_loss_pin_n_oe_out(pin_oe),
    .fll_enable_out(fll));

  task automatic results();
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check_ch(input int c, input logic exp);
    `CHK(alarm[c], exp)
    `CHK(fll[c], exp)
    `CHK(pin_oe[c], exp)
    `CHK(pin_n[c], 1'b0)
  endtask

  // Samples on the falling edge, clear of the updates at the rising edge
  task automatic wait_alarm(input int c, input logic v, input int bound);
    int n;
    n = 0;
    @(negedge clk);
    while (alarm[c] !== v && n < bound) begin
      @(negedge clk);
      n++;
    end
    if (alarm[c] !== v) begin
      error_cnt++;
      $display("ERROR t=%0t timeout on channel %0d", $time, c);
      results();
    end
  endtask

  initial begin
    // Window 8'h25: one acquisition step, narrow two, wide scaled by four
    repeat (2) @(posedge clk);
    @(negedge clk);
    for (int c = 0; c < 4; c++) check_ch(c, 1'b1);
    @(posedge clk);
    rst_n <= 1'b1;
    vdiv[2] <= 8'h02;
    act[3] <= 1'b1;
    wait_alarm(0, 1'b0, 2000);
    wait_alarm(1, 1'b0, 2000);
    check_ch(0, 1'b0);
    check_ch(2, 1'b1);
    check_ch(3, 1'b1);
    @(posedge clk);
    act[3] <= 1'b0;
    wait_alarm(3, 1'b0, 2000);
    @(posedge clk);
    vco_per[0] <= 8'h05;
    vco_per[1] <= 8'h08;
    wait_alarm(1, 1'b1, 2000);
    check_ch(1, 1'b1);
    repeat (600) @(negedge clk);
    check_ch(0, 1'b0);
    @(posedge clk);
    srst[0] <= 1'b1;
    repeat (2) @(negedge clk);
    check_ch(0, 1'b1);
    @(posedge clk);
    vco_per <= {4{8'h04}};
    for (int k = 0; k < 7; k++) begin
      refctl <= {4'h0, 3'(k), 1'b0};
      vdiv <= {8'(ratios[k]), 8'(ratios[k]), 8'(2 * ratios[k]), 8'(ratios[k])};
      srst <= 4'hf;
      repeat (2) @(posedge clk);
      srst <= 4'h0;
      wait_alarm(0, 1'b0, ratios[k] * 1600 + 400);
      wait_alarm(2, 1'b0, 400 + ratios[k] * 200);
      wait_alarm(3, 1'b0, 400 + ratios[k] * 200);
      check_ch(1, 1'b1);
      @(posedge clk);
    end
    // Short interval, narrow two; wide bit clear gives three counts, set gives eight
    win <= {8'h05, 8'h04, 8'h04, 8'h04};
    refctl <= 8'h00;
    vdiv <= {4{8'h01}};
    srst <= 4'hf;
    repeat (2) @(posedge clk);
    srst <= 4'h0;
    wait_alarm(0, 1'b0, 400);
    wait_alarm(3, 1'b0, 400);
    @(posedge clk);
    vco_per[0] <= 8'h06;
    vco_per[3] <= 8'h06;
    wait_alarm(0, 1'b1, 400);
    repeat (200) @(negedge clk);
    check_ch(3, 1'b0);
    check_ch(0, 1'b1);
    results();
  end
endmodule

`default_nettype wire
